/* hw/asrp_cfg.svh */
`ifndef ASRP_CFG_SVH
`define ASRP_CFG_SVH
`define ASRP_CLK_MHZ 10
`define ASRP_ADDR_W 15
`define ASRP_DATA_W 8
`define ASRP_T_CYCLE_NS 25
`define ASRP_T_ACCESS_NS 25
`define ASRP_T_WP_NS 20
`define ASRP_T_WHZ_NS 11
`define ASRP_T_DW_NS 13
`define ASRP_T_AW_NS 20
`define ASRP_T_OW_NS 4
`define ASRP_T_OHZ_NS 10
`define ASRP_CYC(ns) (((ns) * `ASRP_CLK_MHZ + 999) / 1000)
`define ASRP_CNT_W 4
`define ASRP_CNT_ZERO 4'h0
`define ASRP_CNT_ONE 4'h1
`endif

/* hw/asrp_pkg.sv */
package asrp_pkg;
  typedef struct packed {
    logic we;
    logic [14:0] addr;
    logic [7:0] wdata;
  } asrp_req_t;
  typedef struct packed {
    logic cs_n;
    logic oe_n;
    logic we_n;
  } asrp_ctl_t;
  typedef enum logic [2:0] {
    ST_IDLE, ST_RD_SEL, ST_RD_WAIT, ST_WR_SETUP, ST_WR_PULSE, ST_WR_REC,
    ST_RD_OFF
  } asrp_state_t;
endpackage

/* hw/asrp_host.sv */
// Overview of operation
// RULE1 - Write occurs while select and strobe low
// RULE2 - Strobe stays high for every read
// RULE3 - Device updates read data per address
// RULE4 - Address valid by select falling edge
// RULE5 - With drive enable low, stretch strobe
// RULE6 - Drive enable high allows plain pulse width
// RULE7 - No host drive while memory drives
// RULE8 - Late select keeps device outputs off
// RULE9 - Device read data valid after select
// RULE10 - Device data valid after drive enable
// RULE11 - Device holds old data after address
// RULE12 - Address valid long before write end
// RULE13 - Select low long before write end
// RULE14 - Device waits before redriving after write
// RULE15 - Drive enable high during writes
// RULE16 - 32768 bytes, 15-bit address, byte bus
// RULE17 - Memory needs no clock or refresh
`include "asrp_cfg.svh"
module asrp_host #(
  parameter int ACCESS_CYC = `ASRP_CYC(`ASRP_T_ACCESS_NS),
  parameter int WP_CYC = `ASRP_CYC(`ASRP_T_WP_NS),
  parameter int REC_CYC = `ASRP_CYC(`ASRP_T_OW_NS)
) (
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic req_valid_in,
  input wire asrp_pkg::asrp_req_t req_in,
  output logic req_ready_out,
  output logic rd_valid_out,
  output logic [7:0] rd_data_out,
  output logic [14:0] mem_addr_out,
  output logic mem_cs_n_out,
  output logic mem_oe_n_out,
  output logic mem_we_n_out,
  output logic [7:0] mem_dq_out,
  output logic [7:0] mem_dq_oe_out,
  input wire logic [7:0] mem_dq_in
);
  import asrp_pkg::*;

  // Cycle count to counter load, kept inside the counter range
  function automatic logic [`ASRP_CNT_W-1:0] cnt_load(input int cyc);
    if (cyc < 1) begin
      return `ASRP_CNT_ONE;
    end
    if (cyc >= (1 << `ASRP_CNT_W)) begin
      return '1;
    end
    return (`ASRP_CNT_W)'(cyc);
  endfunction

  // Active-high intents to active-low pin levels
  function automatic asrp_ctl_t ctl_word(input logic sel, input logic drv,
    input logic wr);
    asrp_ctl_t c;
    c.cs_n = ~sel;
    c.oe_n = ~drv;
    c.we_n = ~wr;
    return c;
  endfunction

  localparam logic [`ASRP_CNT_W-1:0] ACC_N = cnt_load(ACCESS_CYC);
  localparam logic [`ASRP_CNT_W-1:0] WP_N = cnt_load(WP_CYC);
  localparam logic [`ASRP_CNT_W-1:0] REC_N = cnt_load(REC_CYC);
  localparam asrp_ctl_t CTL_IDLE = ctl_word(1'b0, 1'b0, 1'b0);
  localparam asrp_ctl_t CTL_READ = ctl_word(1'b1, 1'b1, 1'b0);
  localparam asrp_ctl_t CTL_WSEL = ctl_word(1'b1, 1'b0, 1'b0);
  localparam asrp_ctl_t CTL_WPUL = ctl_word(1'b1, 1'b0, 1'b1);

  asrp_state_t st_q, st_d;
  asrp_ctl_t ctl_q, ctl_d;
  logic [`ASRP_CNT_W-1:0] cnt_q, cnt_d;
  logic [`ASRP_ADDR_W-1:0] addr_q, addr_d;
  logic [`ASRP_DATA_W-1:0] wd_q, wd_d;
  logic [`ASRP_DATA_W-1:0] rd_q, rd_d;
  logic dq_oe_q, dq_oe_d;
  logic rv_q, rv_d;
  logic rdy_q, rdy_d;

  // Request and counter decode
  wire cnt_done = (cnt_q == `ASRP_CNT_ONE);
  wire cnt_zero = (cnt_q == `ASRP_CNT_ZERO);
  wire take = rdy_q && req_valid_in;
  wire rd_start = take && !req_in.we;
  wire wr_start = take && req_in.we;
  wire [`ASRP_CNT_W-1:0] cnt_dec = cnt_q - `ASRP_CNT_ONE;

  // Next-state and next-output decode
  always_comb begin
    st_d = st_q;
    ctl_d = ctl_q;
    cnt_d = cnt_done ? `ASRP_CNT_ZERO : cnt_dec;
    if (cnt_zero) cnt_d = `ASRP_CNT_ZERO;
    addr_d = addr_q;
    wd_d = wd_q;
    rd_d = rd_q;
    dq_oe_d = dq_oe_q;
    rv_d = 1'b0;
    rdy_d = rdy_q;
    unique case (st_q)
      ST_IDLE: begin
        if (take) begin
          rdy_d = 1'b0;
          addr_d = req_in.addr; // [RULE4] [RULE16]
        end
        if (wr_start) begin
          wd_d = req_in.wdata;
          ctl_d = CTL_WSEL; // [RULE5] [RULE15]
          st_d = ST_WR_SETUP;
        end
        if (rd_start) begin
          st_d = ST_RD_SEL;
        end
      end
      ST_RD_SEL: begin
        // Address already stable one cycle before select falls
        ctl_d = CTL_READ; // [RULE2] [RULE4]
        cnt_d = ACC_N;
        st_d = ST_RD_WAIT;
      end
      ST_RD_WAIT: begin
        if (cnt_done) begin
          rd_d = mem_dq_in; // [RULE9] [RULE10]
          rv_d = 1'b1;
          ctl_d = CTL_IDLE;
          cnt_d = `ASRP_CNT_ONE;
          st_d = ST_RD_OFF;
        end
      end
      ST_RD_OFF: begin
        // Bus float time before anyone drives again
        if (cnt_zero) begin
          rdy_d = 1'b1;
          st_d = ST_IDLE;
        end
      end
      ST_WR_SETUP: begin
        dq_oe_d = 1'b1; // [RULE7] [RULE15]
        ctl_d = CTL_WPUL; // [RULE1]
        cnt_d = WP_N; // [RULE6] [RULE12] [RULE13]
        st_d = ST_WR_PULSE;
      end
      ST_WR_PULSE: begin
        if (cnt_done) begin
          ctl_d = CTL_IDLE; // [RULE1]
          cnt_d = REC_N;
          st_d = ST_WR_REC;
        end
      end
      ST_WR_REC: begin
        dq_oe_d = 1'b0; // [RULE7]
        if (cnt_zero) begin
          rdy_d = 1'b1;
          st_d = ST_IDLE;
        end
      end
      default: st_d = ST_IDLE;
    endcase
  end

  // Sequencer state and pin controls
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      st_q <= ST_IDLE;
      ctl_q <= CTL_IDLE;
    end else begin
      st_q <= st_d;
      ctl_q <= ctl_d;
    end
  end

  // Timing counter
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      cnt_q <= `ASRP_CNT_ZERO;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // Captured request
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      addr_q <= '0;
      wd_q <= '0;
    end else begin
      addr_q <= addr_d;
      wd_q <= wd_d;
    end
  end

  // Read return
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      rd_q <= '0;
      rv_q <= 1'b0;
    end else begin
      rd_q <= rd_d;
      rv_q <= rv_d;
    end
  end

  // Bus drive and handshake
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      dq_oe_q <= 1'b0;
      rdy_q <= 1'b1;
    end else begin
      dq_oe_q <= dq_oe_d;
      rdy_q <= rdy_d;
    end
  end

  // Outputs straight from registers
  assign req_ready_out = rdy_q;
  assign rd_valid_out = rv_q;
  assign rd_data_out = rd_q;
  assign mem_addr_out = addr_q;
  assign mem_cs_n_out = ctl_q.cs_n;
  assign mem_oe_n_out = ctl_q.oe_n;
  assign mem_we_n_out = ctl_q.we_n;
  assign mem_dq_out = wd_q;
  assign mem_dq_oe_out = {`ASRP_DATA_W{dq_oe_q}};
endmodule

/* sim/asrp_host_props.sv */
module asrp_host_props (
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic req_valid_in,
  input wire asrp_pkg::asrp_req_t req_in,
  input wire logic req_ready_out,
  input wire logic rd_valid_out,
  input wire logic [14:0] mem_addr_out,
  input wire logic mem_cs_n_out,
  input wire logic mem_oe_n_out,
  input wire logic mem_we_n_out,
  input wire logic [7:0] mem_dq_oe_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (reset_in);
  a_rd_we_high: assert property (!mem_oe_n_out |-> mem_we_n_out)
    else $error("strobe low in read");
  a_wr_cs_low: assert property (!mem_we_n_out |-> !mem_cs_n_out)
    else $error("strobe without select");
  a_dq_oe_off: assert property (|mem_dq_oe_out |-> mem_oe_n_out)
    else $error("bus contention");
  a_we_pulse: assert property ($fell(mem_we_n_out) |=> mem_we_n_out)
    else $error("bad strobe width");
  a_cs_before_we: assert property ($fell(mem_we_n_out) |->
    !$past(mem_cs_n_out)) else $error("select late");
  a_addr_at_cs: assert property ($fell(mem_cs_n_out) &&
    !mem_oe_n_out |-> $stable(mem_addr_out)) else $error("address late");
  a_dq_in_write: assert property (!mem_we_n_out |->
    mem_dq_oe_out == 8'hFF) else $error("data not driven");
  a_rd_answer: assert property (req_valid_in && req_ready_out &&
    !req_in.we |-> ##3 rd_valid_out) else $error("no read answer");
  a_wr_oe_high: assert property (!mem_we_n_out |-> mem_oe_n_out)
    else $error("drive enable low in write");
  a_wr_addr_hold: assert property (!mem_we_n_out |=>
    $stable(mem_addr_out)) else $error("address moved at write end");
  a_oe_bus_free: assert property ($fell(mem_oe_n_out) |->
    mem_dq_oe_out == 8'h00 && $past(mem_dq_oe_out) == 8'h00)
    else $error("host drives bus at read");
endmodule
bind asrp_host asrp_host_props u_props (.*);

/* sim/asrp_sram_model.sv */
module asrp_sram_model (
  input wire logic [14:0] addr_in,
  input wire logic cs_n_in,
  input wire logic oe_n_in,
  input wire logic we_n_in,
  input wire logic [7:0] bus_in,
  output logic [7:0] q_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem_q [32768];
  wire logic drive = !cs_n_in && !oe_n_in && we_n_in;
  always @(posedge (cs_n_in | we_n_in)) mem_q[addr_in] <= bus_in;
  // Released bus shows the inverse
  assign q_out = drive ? mem_q[addr_in] : ~mem_q[addr_in];
endmodule

/* sim/asrp_host_tb_top.sv */
module asrp_host_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import asrp_pkg::*;
  logic clk_sys_in = 1'b0;
  logic reset_in = 1'b1;
  logic vld = 1'b0;
  asrp_req_t rq = '0;
  logic rdy, rv, cs_n, oe_n, we_n;
  logic [7:0] rd, dq, dq_oe, q, bus;
  logic [14:0] ma;
  logic [7:0] exp_q [$];
  logic [14:0] ad [4] = '{15'h0000, 15'h7FFF, 15'h0000, 15'h0000};
  logic [7:0] dt [4];
  int mismatches = 0;
  int check_count = 0;
  always #50 clk_sys_in = ~clk_sys_in;
  assign bus = (dq_oe & dq) | (~dq_oe & q);
  asrp_host DUT (.clk_sys_in, .reset_in, .req_valid_in(vld), .req_in(rq),
    .req_ready_out(rdy), .rd_valid_out(rv), .rd_data_out(rd),
    .mem_addr_out(ma), .mem_cs_n_out(cs_n), .mem_oe_n_out(oe_n),
    .mem_we_n_out(we_n), .mem_dq_out(dq), .mem_dq_oe_out(dq_oe),
    .mem_dq_in(bus));
  asrp_sram_model u_mem (.addr_in(ma), .cs_n_in(cs_n), .oe_n_in(oe_n),
    .we_n_in(we_n), .bus_in(bus), .q_out(q));
  task automatic cmp(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic req(input logic w, input logic [14:0] a, input logic [7:0] d);
    int n;
    logic hit;
    n = 0;
    hit = 1'b0;
    #1 vld = 1'b1;
    rq = '{w, a, d};
    while (!hit && n < 20) begin
      @(negedge clk_sys_in);
      hit = (rdy === 1'b1);
      @(posedge clk_sys_in);
      n++;
    end
    if (!hit) mismatches++;
  endtask
  task automatic give_verdict;
    $display("mismatches %0d checks %0d", mismatches, check_count);
    if (mismatches == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(negedge clk_sys_in) if (rv === 1'b1) begin
    cmp(rd, exp_q.size() > 0 ? exp_q.pop_front() : ~rd);
  end
  initial begin
    #100000;
    mismatches++;
    give_verdict;
  end
  initial begin
    void'($urandom(98));
    repeat (4) @(posedge clk_sys_in);
    #1 reset_in = 1'b0;
    @(posedge clk_sys_in);
    for (int i = 0; i < 4; i++) begin
      if (i > 1) ad[i] = 15'($urandom);
      dt[i] = 8'($urandom);
      req(1'b1, ad[i], dt[i]);
      for (int j = 0; j < i; j++) begin
        if (ad[j] == ad[i]) dt[j] = dt[i];
      end
    end
    for (int i = 3; i >= 0; i--) begin
      exp_q.push_back(dt[i]);
      req(1'b0, ad[i], 8'($urandom));
    end
    #1 vld = 1'b0;
    repeat (10) @(posedge clk_sys_in);
    cmp(8'(exp_q.size()), 8'h00);
    give_verdict;
  end
endmodule
